// ### hw/rps_pkg.sv
// constants and register map of the remappable pin select block
package rps_pkg;

  // ---------------------------------------------------------------
  // register map (word index, byte address = index * 4)
  // ---------------------------------------------------------------
  localparam int unsigned REG_COUNT                = 14;
  localparam int unsigned REG_IDX_W                = 4;
  localparam int unsigned ADDR_W                   = 6;
  localparam int unsigned REG_W                    = 16;
  localparam int unsigned BUS_W                    = 32;
  localparam int unsigned BE_W                     = 4;
  localparam int unsigned BYTE_W                   = 8;
  localparam int unsigned WORD_LSB                 = 2;

  localparam logic [3:0] UART3_RX_INPUT_ROUTE           = 4'h0;
  localparam logic [3:0] UART1_RX_CTS_INPUT_ROUTE       = 4'h1;
  localparam logic [3:0] UART2_RX_CTS_INPUT_ROUTE       = 4'h2;
  localparam logic [3:0] SPI1_CLOCK_DATA_INPUT_ROUTE    = 4'h3;
  localparam logic [3:0] UART3_CTS_SPI1_SEL_INPUT_ROUTE = 4'h4;
  localparam logic [3:0] SPI2_CLOCK_DATA_INPUT_ROUTE    = 4'h5;
  localparam logic [3:0] SPI2_SELECT_INPUT_ROUTE        = 4'h6;
  localparam logic [3:0] UART4_RX_CTS_INPUT_ROUTE       = 4'h7;
  localparam logic [3:0] SPI3_CLOCK_DATA_INPUT_ROUTE    = 4'h8;
  localparam logic [3:0] SPI3_SELECT_INPUT_ROUTE        = 4'h9;
  localparam logic [3:0] PINS_0_1_OUTPUT_ROUTE          = 4'ha;
  localparam logic [3:0] PINS_2_3_OUTPUT_ROUTE          = 4'hb;
  localparam logic [3:0] PINS_4_5_OUTPUT_ROUTE          = 4'hc;
  localparam logic [3:0] PINS_6_7_OUTPUT_ROUTE          = 4'hd;

  // ---------------------------------------------------------------
  // field layout
  // ---------------------------------------------------------------
  localparam int unsigned SEL_W      = 6;
  localparam int unsigned LO_LSB     = 0;
  localparam int unsigned HI_LSB     = 8;
  localparam logic [15:0] FIELD_LO   = 16'h003f;
  localparam logic [15:0] FIELD_HI   = 16'h3f00;
  localparam logic [15:0] FIELD_BOTH = 16'h3f3f;
  localparam logic [15:0] FIELD_NONE = 16'h0000;

  // implemented bits per register
  localparam logic [15:0] REG_MASK [REG_COUNT] = '{
    FIELD_HI, FIELD_BOTH, FIELD_BOTH, FIELD_BOTH, FIELD_BOTH, FIELD_BOTH, FIELD_LO,
    FIELD_BOTH, FIELD_BOTH, FIELD_LO,
    FIELD_BOTH, FIELD_BOTH, FIELD_BOTH, FIELD_BOTH};

  // input selects reset to all ones, output selects to zero
  localparam logic [15:0] REG_RESET [REG_COUNT] = '{
    FIELD_HI, FIELD_BOTH, FIELD_BOTH, FIELD_BOTH, FIELD_BOTH, FIELD_BOTH, FIELD_LO,
    FIELD_BOTH, FIELD_BOTH, FIELD_LO,
    FIELD_NONE, FIELD_NONE, FIELD_NONE, FIELD_NONE};

  // ---------------------------------------------------------------
  // peripheral input routing table (bit of PERIPH_IN)
  // ---------------------------------------------------------------
  localparam int unsigned IN_COUNT = 17;
  // 0 u1 rx, 1 u1 cts, 2 u2 rx, 3 u2 cts, 4 u3 rx, 5 u3 cts, 6 u4 rx, 7 u4 cts,
  // 8 spi1 clk, 9 spi1 data, 10 spi1 sel, 11 spi2 clk, 12 spi2 data,
  // 13 spi2 sel, 14 spi3 clk, 15 spi3 data, 16 spi3 sel
  localparam logic [3:0] IN_REG [IN_COUNT] = '{
    UART1_RX_CTS_INPUT_ROUTE, UART1_RX_CTS_INPUT_ROUTE,
    UART2_RX_CTS_INPUT_ROUTE, UART2_RX_CTS_INPUT_ROUTE,
    UART3_RX_INPUT_ROUTE, UART3_CTS_SPI1_SEL_INPUT_ROUTE,
    UART4_RX_CTS_INPUT_ROUTE, UART4_RX_CTS_INPUT_ROUTE,
    SPI1_CLOCK_DATA_INPUT_ROUTE, SPI1_CLOCK_DATA_INPUT_ROUTE,
    UART3_CTS_SPI1_SEL_INPUT_ROUTE,
    SPI2_CLOCK_DATA_INPUT_ROUTE, SPI2_CLOCK_DATA_INPUT_ROUTE, SPI2_SELECT_INPUT_ROUTE,
    SPI3_CLOCK_DATA_INPUT_ROUTE, SPI3_CLOCK_DATA_INPUT_ROUTE, SPI3_SELECT_INPUT_ROUTE};
  localparam int unsigned IN_LSB [IN_COUNT] = '{
    LO_LSB, HI_LSB, LO_LSB, HI_LSB, HI_LSB, HI_LSB, LO_LSB, HI_LSB,
    HI_LSB, LO_LSB, LO_LSB, HI_LSB, LO_LSB, LO_LSB, HI_LSB, LO_LSB, LO_LSB};

  // ---------------------------------------------------------------
  // pins and functions
  // ---------------------------------------------------------------
  localparam int unsigned PIN_COUNT      = 8;
  localparam int unsigned PIN_IDX_W      = 3;
  localparam int unsigned SMALL_PKG_PIN  = 5;
  localparam int unsigned FUNC_COUNT     = 64;
  localparam logic [5:0]  FUNC_NONE      = 6'h00;
  localparam logic        INACTIVE_LEVEL = 1'b1;

endpackage

// ### hw/rps_pin_select.sv
// remappable pin select: routing registers on avalon-mm and the pin matrix
// ---------------------------------------------------------------
// ---------------------------------------------------------------
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/100ps
module rps_pin_select
  import rps_pkg::*;
#(
  parameter bit SMALL_PACKAGE = 1'b0
) (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RST,
  input  wire logic                  CE,
  input  wire logic [ADDR_W-1:0]     AVS_ADDRESS,
  input  wire logic                  AVS_READ,
  input  wire logic                  AVS_WRITE,
  input  wire logic [BUS_W-1:0]      AVS_WRITEDATA,
  input  wire logic [BE_W-1:0]       AVS_BYTEENABLE,
  output logic      [BUS_W-1:0]      AVS_READDATA,
  output logic                       AVS_WAITREQUEST,
  input  wire logic [PIN_COUNT-1:0]  REMAPPABLE_PIN_IN,
  input  wire logic [FUNC_COUNT-1:0] PERIPH_OUT_FUNC,
  output logic      [IN_COUNT-1:0]   PERIPH_IN,
  output logic      [PIN_COUNT-1:0]  REMAPPABLE_PIN_OUT,
  output logic      [PIN_COUNT-1:0]  REMAPPABLE_PIN_OE
);

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  logic [REG_W-1:0]     route_q [REG_COUNT];
  logic [REG_W-1:0]     route_d [REG_COUNT];
  logic                 ack_q;
  logic                 ack_d;
  logic [REG_W-1:0]     rdata_q;
  logic [REG_W-1:0]     rdata_d;
  logic                 req;
  logic                 hit;
  logic [REG_IDX_W-1:0] idx;
  logic [REG_W-1:0]     wmask;

  function automatic logic [REG_W-1:0] impl_mask(input logic [REG_IDX_W-1:0] i);
    logic [REG_W-1:0] m;
    m = REG_MASK[i];
    if (SMALL_PACKAGE && i == PINS_4_5_OUTPUT_ROUTE) begin
      m = m & ~FIELD_HI;
    end
    return m;
  endfunction

  assign req = AVS_READ | AVS_WRITE;
  assign idx = AVS_ADDRESS[ADDR_W-1:WORD_LSB];
  assign hit = (AVS_ADDRESS[WORD_LSB-1:0] == '0) && (idx < REG_IDX_W'(REG_COUNT));
  // one wait cycle; a frozen block keeps the master waiting
  assign AVS_WAITREQUEST = req & ~(ack_q & CE);
  assign AVS_READDATA = {{(BUS_W-REG_W){1'b0}}, rdata_q};

  always_comb begin
    wmask = {{BYTE_W{AVS_BYTEENABLE[1]}}, {BYTE_W{AVS_BYTEENABLE[0]}}};
    route_d = route_q;
    ack_d = req & ~ack_q;
    rdata_d = rdata_q;
    if (req && !ack_q && AVS_READ) begin
      rdata_d = hit ? route_q[idx] : '0;
    end
    if (AVS_WRITE && ack_q && hit) begin
      wmask = wmask & impl_mask(idx);
      route_d[idx] = (route_q[idx] & ~wmask) | (AVS_WRITEDATA[REG_W-1:0] & wmask);
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      route_q <= REG_RESET;
      ack_q   <= 1'b0;
      rdata_q <= '0;
    end else if (CE) begin
      route_q <= route_d;
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // routing matrix
  // ---------------------------------------------------------------
  logic [IN_COUNT-1:0]  periph_in_d;
  logic [PIN_COUNT-1:0] pin_out_d;
  logic [PIN_COUNT-1:0] pin_oe_d;

  genvar g;
  generate
    for (g = 0; g < IN_COUNT; g++) begin : g_in
      logic [SEL_W-1:0] sel;
      assign sel = route_q[IN_REG[g]][IN_LSB[g] +: SEL_W];
      // the reset value of all ones names no pin, so inputs idle cleanly
      assign periph_in_d[g] = (sel < SEL_W'(PIN_COUNT)) ?
                              REMAPPABLE_PIN_IN[sel[PIN_IDX_W-1:0]] : INACTIVE_LEVEL;
    end
    for (g = 0; g < PIN_COUNT; g++) begin : g_out
      logic [SEL_W-1:0] func;
      assign func = route_q[PINS_0_1_OUTPUT_ROUTE + g / 2][(g % 2) * HI_LSB +: SEL_W];
      assign pin_out_d[g] = (func != FUNC_NONE) & PERIPH_OUT_FUNC[func];
      assign pin_oe_d[g]  = (func != FUNC_NONE);
    end
  endgenerate

  // registered so pins never see select glitches while software rewrites
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      PERIPH_IN          <= {IN_COUNT{INACTIVE_LEVEL}};
      REMAPPABLE_PIN_OUT <= '0;
      REMAPPABLE_PIN_OE  <= '0;
    end else if (CE) begin
      PERIPH_IN          <= periph_in_d;
      REMAPPABLE_PIN_OUT <= pin_out_d;
      REMAPPABLE_PIN_OE  <= pin_oe_d;
    end
  end

endmodule

// ### verification/rps_pin_select_chk.sv
// bus and routing assertions for the pin select block
`timescale 1ns/100ps
module rps_pin_select_chk
  import rps_pkg::*;
(
  input wire logic                 CLK_SYS,
  input wire logic                 RST,
  input wire logic                 CE,
  input wire logic [ADDR_W-1:0]    AVS_ADDRESS,
  input wire logic                 AVS_READ,
  input wire logic                 AVS_WRITE,
  input wire logic [BUS_W-1:0]     AVS_WRITEDATA,
  input wire logic [BE_W-1:0]      AVS_BYTEENABLE,
  input wire logic [BUS_W-1:0]     AVS_READDATA,
  input wire logic                 AVS_WAITREQUEST,
  input wire logic [IN_COUNT-1:0]  PERIPH_IN,
  input wire logic [PIN_COUNT-1:0] REMAPPABLE_PIN_OUT,
  input wire logic [PIN_COUNT-1:0] REMAPPABLE_PIN_OE
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire rd_ok = AVS_READ && !AVS_WAITREQUEST;
  wire wr_lo = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  a_reset_defaults: assert property ($fell(RST) |-> &PERIPH_IN && !REMAPPABLE_PIN_OE)
    else $error("routing outputs wrong after reset");
  a_one_wait: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CE |=> !AVS_WAITREQUEST)
    else $error("access did not end after one wait state");
  a_idle_no_wait: assert property (!AVS_READ && !AVS_WRITE |-> !AVS_WAITREQUEST)
    else $error("wait raised while idle");
  a_unimpl_zero: assert property (rd_ok |-> (AVS_READDATA & 32'hffffc0c0) == 0)
    else $error("unimplemented bits read nonzero");
  a_unmapped_zero: assert property (rd_ok && AVS_ADDRESS >= 6'h38 |-> AVS_READDATA == 0)
    else $error("unmapped read nonzero");
  a_undriven_low: assert property ((REMAPPABLE_PIN_OUT & ~REMAPPABLE_PIN_OE) == 0)
    else $error("undriven pin shows a level");
  a_route_delay: assert property (wr_lo && AVS_ADDRESS == 6'h28 |->
    ##2 REMAPPABLE_PIN_OE[0] == (($past(AVS_WRITEDATA, 2) & 32'h3f) != 0))
    else $error("pin drive did not follow write");
  a_absent_pin_idle: assert property (wr_lo && AVS_ADDRESS == 6'h04 && AVS_WRITEDATA[5:3] != 0 |->
    ##2 PERIPH_IN[0] [*2])
    else $error("absent pin selection not idle");
endmodule
bind rps_pin_select rps_pin_select_chk rps_chk_u (.*);

// ### verification/test_remappable_pin_select.sv
// self-checking bench for the pin select block
`timescale 1ns/100ps
module test_remappable_pin_select
  import rps_pkg::*;
;
  logic              CLK_SYS = 1'b0, RST = 1'b1, CE = 1'b1, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [ADDR_W-1:0] AVS_ADDRESS = 6'h00;
  logic [BUS_W-1:0]  AVS_WRITEDATA = 32'h0, AVS_READDATA;
  logic [BE_W-1:0]   AVS_BYTEENABLE = 4'h0;
  logic [7:0]        REMAPPABLE_PIN_IN = 8'h5a, REMAPPABLE_PIN_OUT, REMAPPABLE_PIN_OE;
  logic [63:0]       PERIPH_OUT_FUNC = {16{4'h9}};
  logic [16:0]       PERIPH_IN;
  logic              AVS_WAITREQUEST;
  logic [15:0]       v, m, vs;
  logic [BUS_W-1:0]  rd_small;
  logic [7:0]        oe_small;
  int                fails = 0, n_compared = 0;
  rps_pin_select dut_u (.*);
  // second copy in the small package variant, driven by the same bus
  rps_pin_select #(.SMALL_PACKAGE(1'b1)) dut_small_u (
    .CLK_SYS            (CLK_SYS),
    .RST                (RST),
    .CE                 (CE),
    .AVS_ADDRESS        (AVS_ADDRESS),
    .AVS_READ           (AVS_READ),
    .AVS_WRITE          (AVS_WRITE),
    .AVS_WRITEDATA      (AVS_WRITEDATA),
    .AVS_BYTEENABLE     (AVS_BYTEENABLE),
    .AVS_READDATA       (rd_small),
    .AVS_WAITREQUEST    (),
    .REMAPPABLE_PIN_IN  (REMAPPABLE_PIN_IN),
    .PERIPH_OUT_FUNC    (PERIPH_OUT_FUNC),
    .PERIPH_IN          (),
    .REMAPPABLE_PIN_OUT (),
    .REMAPPABLE_PIN_OE  (oe_small)
  );
  initial forever #5 CLK_SYS = ~CLK_SYS;
  // ----
  // tasks
  // ----
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one idle edge first, so a release and the next request never share a time step
  task automatic bus(input logic wr, input logic [5:0] a, input logic [15:0] d);
    @(posedge CLK_SYS);
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {16'h0000, d};
    AVS_BYTEENABLE <= (d == 16'h0bad) ? 4'h1 : 4'hf;
    repeat (50) begin
      @(negedge CLK_SYS);
      if (AVS_WAITREQUEST === 1'b0) break;
    end
    if (AVS_WAITREQUEST !== 1'b0) begin
      fails++;
      tally_and_finish();
    end
    @(posedge CLK_SYS);
    v = AVS_READDATA[15:0];
    vs = rd_small[15:0];
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  initial begin
    repeat (20) @(posedge CLK_SYS);
    RST <= 1'b0;
    for (int i = 0; i < 15; i++) begin
      m = (i == 0) ? 16'h3f00 : (i == 6 || i == 9) ? 16'h003f : (i > 13) ? 16'h0 : 16'h3f3f;
      bus(0, 6'(i * 4), 0);
      chk("reset value", v, (i < 10) ? m : 16'h0);
      bus(1, 6'(i * 4), 16'hffff);
      bus(0, 6'(i * 4), 0);
      chk("masked readback", v, m);
      if (i == 12) chk("small package pin five", {oe_small[5], vs}, 17'h0003f);
    end
    // low lane only: upper field keeps its ones
    bus(1, 6'h0c, 16'h0bad);
    bus(0, 6'h0c, 0);
    chk("byte lane", v, 16'h3f2d);
    $display("register tests done");
    for (int k = 0; k < IN_COUNT; k++) begin
      for (int p = 0; p < 9; p++) begin
        bus(1, {IN_REG[k], 2'b00}, 16'(p == 8 ? 63 : p) << IN_LSB[k]);
        repeat (2) @(posedge CLK_SYS);
        chk("peripheral input", PERIPH_IN[k], p == 8 ? 1'b1 : REMAPPABLE_PIN_IN[p]);
      end
    end
    $display("input routing done");
    for (int q = 0; q < 8; q++) begin
      bus(1, 6'h28 + 6'(q / 2 * 4), 16'(q * 7 + 1) << (q % 2 * 8));
      repeat (2) @(posedge CLK_SYS);
      chk("pin output", {REMAPPABLE_PIN_OE[q], REMAPPABLE_PIN_OUT[q]},
          {1'b1, PERIPH_OUT_FUNC[q * 7 + 1]});
    end
    $display("output routing done");
    tally_and_finish();
  end
endmodule
